//--- rtl/pcr_defines.vh
`ifndef PCR_DEFINES_VH
`define PCR_DEFINES_VH

// Register addresses in the special function space
`define PCR_ADDR_PWR 8'h87
`define PCR_ADDR_SER 8'h98
`define PCR_ADDR_WDP 8'hA7

// Power control field positions
`define PCR_B_DBL  7
`define PCR_B_SEL  6
`define PCR_B_RSV  5
`define PCR_B_COLD 4
`define PCR_B_UF1  3
`define PCR_B_UF0  2
`define PCR_B_PD   1
`define PCR_B_IDL  0

// Serial control field positions
`define PCR_B_SM0  7
`define PCR_B_SM1  6
`define PCR_SER_LO 5

// Watchdog program field positions
`define PCR_WD_HI  2

// Values
`define PCR_ZERO8  8'h00
`define PCR_ZERO6  6'h00
`define PCR_ZERO3  3'h0
`define PCR_MODE0  2'h0
`define PCR_CLR    1'h0
`define PCR_SET    1'h1

`endif

//--- rtl/pcr_power_control.v
`timescale 1ns/1ps
`include "pcr_defines.vh"

// Functional notes
// - Select clear: top serial bit is mode bit
// - Select set: top serial bit is fault flag
// - Select enables stop check; fault flag sticky
// - Cold power-up sets cold start flag
// - Software may clear cold start flag
// - Software may set cold start flag
// - Only cold power-up presets cold flag
// - Two user flags are plain storage
// - Writing one enters power-down
// - Reset clears power-down bit
// - Idle bit cleared by interrupt, reset
// - Bit five reserved; writes ignored
// - Reset value 00X1 0000b, byte access
module pcr_power_control (
	ref_clk,
	rst_n,
	cold_power_on,
	addr,
	wdata,
	wr_en,
	rd_en,
	irq_event,
	rx_frame_done,
	rx_stop_bit,
	rdata,
	light_sleep,
	power_down,
	baud_double,
	stop_check_en,
	serial_mode,
	wd_timeout_sel
);
	input  wire       ref_clk;
	input  wire       rst_n;
	input  wire       cold_power_on;
	input  wire [7:0] addr;
	input  wire [7:0] wdata;
	input  wire       wr_en;
	input  wire       rd_en;
	input  wire       irq_event;
	input  wire       rx_frame_done;
	input  wire       rx_stop_bit;
	output reg  [7:0] rdata;
	output reg        light_sleep;
	output reg        power_down;
	output reg        baud_double;
	output reg        stop_check_en;
	output reg  [1:0] serial_mode;
	output reg  [2:0] wd_timeout_sel;

	////////////////////////////////////////////////////////////
	// Storage

	reg       baud_doubler_bit;
	reg       serial_bit_select;
	reg       cold_start_flag;
	reg       user_flag_one;
	reg       user_flag_zero;
	reg       power_down_request;
	reg       light_sleep_request;
	reg       serial_mode_high_bit;
	reg       serial_mode_low_bit;
	reg       frame_fault_flag;
	reg [5:0] serial_low;
	reg [2:0] wd_sel;
	reg       por_meta;
	reg       por_sync;

	reg       next_cold;
	reg       next_pd;
	reg       next_idl;
	reg       next_fault;
	reg       next_sm_hi;
	reg [7:0] next_rdata;
	reg [7:0] pwr_view;
	reg [7:0] ser_view;
	reg [7:0] wdp_view;

	wire      wr_pwr;
	wire      wr_ser;
	wire      wr_wdp;
	wire      mode_async;
	wire      fault_event;

	////////////////////////////////////////////////////////////
	// Decode

	// Plain port: one-cycle strobes, no wait states
	// Full address compare: aliasing would let a stray access
	// to a neighbour register disturb the sleep controls
	assign wr_pwr = wr_en && (addr == `PCR_ADDR_PWR);
	assign wr_ser = wr_en && (addr == `PCR_ADDR_SER);
	assign wr_wdp = wr_en && (addr == `PCR_ADDR_WDP);

	// Modes 1, 2 and 3 are the asynchronous ones
	// Mode 0 is the shift register mode; framing and doubling do not apply
	assign mode_async = ({serial_mode_high_bit, serial_mode_low_bit} != `PCR_MODE0);

	// A frame with a good stop bit never clears the flag
	// Stop bit check
	assign fault_event = rx_frame_done && serial_bit_select &&
		mode_async && !rx_stop_bit;

	////////////////////////////////////////////////////////////
	// Power-on level synchroniser

	// Power-on detect comes from the supply monitor, another domain
	// No reset here: the level must pass through while rst_n is low
	// Only por_sync is read by logic; por_meta may go metastable
	always @(posedge ref_clk) begin
		por_meta <= cold_power_on;
		por_sync <= por_meta;
	end

	////////////////////////////////////////////////////////////
	// Cold start flag

	// Survives a warm reset: rst_n never clears it, it only blocks software writes
	// Before the first power-on pulse the flag is unknown; the supply
	// monitor raises its level at start, which defines it
	always @* begin
		next_cold = cold_start_flag;
		if (rst_n && wr_pwr) begin
			next_cold = wdata[`PCR_B_COLD];
		end
		// Checked last, so a supply event beats a software write
		// Power-up sets flag
		if (por_sync) begin
			next_cold = `PCR_SET;
		end
	end

	always @(posedge ref_clk) begin
		cold_start_flag <= next_cold;
	end

	////////////////////////////////////////////////////////////
	// Plain control bits of power control

	// Reserved bit 5 has no storage, so its reset value needs none
	// Reset value 00X1 0000b
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			baud_doubler_bit  <= `PCR_CLR;
			serial_bit_select <= `PCR_CLR;
			user_flag_one     <= `PCR_CLR;
			user_flag_zero    <= `PCR_CLR;
		end else if (wr_pwr) begin
			baud_doubler_bit  <= wdata[`PCR_B_DBL];
			serial_bit_select <= wdata[`PCR_B_SEL];
			user_flag_one     <= wdata[`PCR_B_UF1];
			user_flag_zero    <= wdata[`PCR_B_UF0];
		end
	end

	////////////////////////////////////////////////////////////
	// Power-down and idle requests

	// A reset or a power control write with bit 1 clear ends power-down
	// Stopping the oscillator is left to the clock controller outside
	always @* begin
		next_pd = power_down_request;
		if (wr_pwr) begin
			next_pd = wdata[`PCR_B_PD];
		end
	end

	// Write of one beats a same-cycle interrupt: entry is not lost
	// Any power control write rewrites idle, as it is a plain bit
	always @* begin
		next_idl = light_sleep_request;
		if (irq_event) begin
			next_idl = `PCR_CLR;
		end
		if (wr_pwr && wdata[`PCR_B_IDL]) begin
			next_idl = `PCR_SET;
		end else if (wr_pwr) begin
			next_idl = `PCR_CLR;
		end
	end

	always @(posedge ref_clk) begin
		if (!rst_n) begin
			power_down_request  <= `PCR_CLR;
			light_sleep_request <= `PCR_CLR;
		end else begin
			power_down_request  <= next_pd;
			light_sleep_request <= next_idl;
		end
	end

	////////////////////////////////////////////////////////////
	// Serial control: shared top position

	// With select set, the mode high bit is hidden and keeps its value
	always @* begin
		next_sm_hi = serial_mode_high_bit;
		if (wr_ser && !serial_bit_select) begin
			next_sm_hi = wdata[`PCR_B_SM0];
		end
	end

	// Hardware set wins over a same-cycle software clear
	always @* begin
		next_fault = frame_fault_flag;
		if (wr_ser && serial_bit_select) begin
			next_fault = wdata[`PCR_B_SM0];
		end
		if (fault_event) begin
			next_fault = `PCR_SET;
		end
	end

	// Low bits are plain storage for the receiver's other controls
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			serial_mode_high_bit <= `PCR_CLR;
			serial_mode_low_bit  <= `PCR_CLR;
			frame_fault_flag     <= `PCR_CLR;
			serial_low           <= `PCR_ZERO6;
		end else begin
			serial_mode_high_bit <= next_sm_hi;
			frame_fault_flag     <= next_fault;
			if (wr_ser) begin
				serial_mode_low_bit <= wdata[`PCR_B_SM1];
				serial_low <= wdata[`PCR_SER_LO:0];
			end
		end
	end

	////////////////////////////////////////////////////////////
	// Watchdog program

	// Upper five bits are not stored; writes to them are dropped
	// Time-out selection is decoded by the watchdog counter outside
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			wd_sel <= `PCR_ZERO3;
		end else if (wr_wdp) begin
			wd_sel <= wdata[`PCR_WD_HI:0];
		end
	end

	////////////////////////////////////////////////////////////
	// Read views

	always @* begin
		pwr_view = `PCR_ZERO8;
		pwr_view[`PCR_B_DBL]  = baud_doubler_bit;
		pwr_view[`PCR_B_SEL]  = serial_bit_select;
		// Any value is allowed; a constant keeps reads repeatable
		// Reserved reads zero
		pwr_view[`PCR_B_RSV]  = `PCR_CLR;
		pwr_view[`PCR_B_COLD] = cold_start_flag;
		pwr_view[`PCR_B_UF1]  = user_flag_one;
		pwr_view[`PCR_B_UF0]  = user_flag_zero;
		pwr_view[`PCR_B_PD]   = power_down_request;
		pwr_view[`PCR_B_IDL]  = light_sleep_request;
	end

	always @* begin
		ser_view = `PCR_ZERO8;
		ser_view[`PCR_SER_LO:0] = serial_low;
		ser_view[`PCR_B_SM1] = serial_mode_low_bit;
		if (serial_bit_select) begin
			ser_view[`PCR_B_SM0] = frame_fault_flag;
		end else begin
			ser_view[`PCR_B_SM0] = serial_mode_high_bit;
		end
	end

	always @* begin
		wdp_view = `PCR_ZERO8;
		wdp_view[`PCR_WD_HI:0] = wd_sel;
	end

	// Unmapped addresses read as zero
	// Read data are zero outside the answer cycle, so stale values
	// from an earlier read never show on the bus
	always @* begin
		next_rdata = `PCR_ZERO8;
		if (rd_en) begin
			case (addr)
				`PCR_ADDR_PWR: begin
					next_rdata = pwr_view;
				end
				`PCR_ADDR_SER: begin
					next_rdata = ser_view;
				end
				`PCR_ADDR_WDP: begin
					next_rdata = wdp_view;
				end
				default: begin
					next_rdata = `PCR_ZERO8;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////
	// Registered outputs

	// Outputs lag the stored bits by one cycle
	// That lag costs a cycle of sleep latency but keeps every pin
	// glitch free, straight from a flip-flop
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			rdata          <= `PCR_ZERO8;
			light_sleep    <= `PCR_CLR;
			power_down     <= `PCR_CLR;
			baud_double    <= `PCR_CLR;
			stop_check_en  <= `PCR_CLR;
			serial_mode    <= `PCR_MODE0;
			wd_timeout_sel <= `PCR_ZERO3;
		end else begin
			rdata          <= next_rdata;
			light_sleep    <= light_sleep_request;
			power_down     <= power_down_request;
			baud_double    <= baud_doubler_bit && mode_async;
			stop_check_en  <= serial_bit_select;
			serial_mode    <= {serial_mode_high_bit, serial_mode_low_bit};
			wd_timeout_sel <= wd_sel;
		end
	end

endmodule // pcr_power_control

//--- sim/pcr_power_control_props.sv
`timescale 1ns/1ps
// Port-level checks; the bind below attaches them to every instance
module pcr_power_control_props (
	input logic       ref_clk,
	input logic       rst_n,
	input logic [7:0] addr,
	input logic [7:0] wdata,
	input logic       wr_en,
	input logic       rd_en,
	input logic       irq_event,
	input logic       rx_frame_done,
	input logic       rx_stop_bit,
	input logic [7:0] rdata,
	input logic       light_sleep,
	input logic       power_down,
	input logic       baud_double,
	input logic       stop_check_en,
	input logic [1:0] serial_mode
);
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	// Mode pins trail the stored bits by one cycle
	a_pd_write: assert property (wr_en && addr == 8'h87 && wdata[1] |=> ##1 power_down)
		else $error("power down not entered");
	a_pd_reset: assert property (disable iff (1'b0) !rst_n ##1 !rst_n |-> !power_down)
		else $error("power down kept over reset");
	a_idle_irq: assert property (irq_event && !wr_en |=> ##1 !light_sleep)
		else $error("idle kept after interrupt");
	a_rsv_zero: assert property (rd_en && addr == 8'h87 |=> !rdata[5])
		else $error("reserved bit read as one");
	a_user_flags: assert property (wr_en && addr == 8'h87 ##2 rd_en && addr == 8'h87 |=>
		rdata[3:2] == $past(wdata[3:2], 3)) else $error("user flags lost");
	// Fault must be visible to a read two cycles after the bad frame
	// Pins lag the select and mode bits, so they are looked at a cycle on
	a_fault_set: assert property (rx_frame_done && !rx_stop_bit ##1 stop_check_en &&
		serial_mode != 2'h0 && !wr_en ##1 rd_en && addr == 8'h98 |=> rdata[7])
		else $error("frame fault not flagged");
	a_mode_sel: assert property (wr_en && addr == 8'h98 ##1 !stop_check_en |=>
		serial_mode == $past(wdata[7:6], 2)) else $error("mode bits not written");
	a_baud_gate: assert property (serial_mode == 2'h0 |-> !baud_double)
		else $error("doubler active in mode 0");
endmodule // pcr_power_control_props

bind pcr_power_control pcr_power_control_props pcr_power_control_props_i (
	.ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
	.rd_en(rd_en), .irq_event(irq_event), .rx_frame_done(rx_frame_done),
	.rx_stop_bit(rx_stop_bit), .rdata(rdata), .light_sleep(light_sleep),
	.power_down(power_down), .baud_double(baud_double), .stop_check_en(stop_check_en),
	.serial_mode(serial_mode)
);

//--- sim/test_power_control_register.sv
`timescale 1ns/1ps
// Register-port bench; the mode pins are packed into one byte for comparison
module test_power_control_register;
	logic       ref_clk = 1'b0;
	logic       rst_n = 1'b0;
	logic       cold_power_on = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic       wr_en = 1'b0;
	logic       rd_en = 1'b0;
	logic       irq_event = 1'b0;
	logic       rx_frame_done = 1'b0;
	logic       rx_stop_bit = 1'b1;
	wire  [7:0] rdata;
	wire        light_sleep, power_down, baud_double, stop_check_en;
	wire  [1:0] serial_mode;
	wire  [2:0] wd_timeout_sel;
	wire  [7:0] outs = {baud_double, serial_mode, light_sleep, power_down, wd_timeout_sel};
	int         failures = 0;
	int         check_count = 0;
	int         cycles = 0;

	pcr_power_control pcr_power_control_i (
		.ref_clk(ref_clk), .rst_n(rst_n), .cold_power_on(cold_power_on), .addr(addr),
		.wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .irq_event(irq_event),
		.rx_frame_done(rx_frame_done), .rx_stop_bit(rx_stop_bit), .rdata(rdata),
		.light_sleep(light_sleep), .power_down(power_down), .baud_double(baud_double),
		.stop_check_en(stop_check_en), .serial_mode(serial_mode),
		.wd_timeout_sel(wd_timeout_sel)
	);

	////////////////////////////////////////////////////////////////////////////
	// 100 MHz clock
	initial forever #5 ref_clk = ~ref_clk;

	task automatic end_sim;
		if (failures == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Hang guard: the whole sequence needs about a hundred cycles
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			failures++;
			end_sim;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		check_count++;
		if (s !== e) begin
			failures++;
			$display("Error at %0t: saw %h expected %h", $time, s, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		wr_en <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge ref_clk);
		wr_en <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		rd_en <= 1'b1;
		addr <= a;
		@(posedge ref_clk);
		rd_en <= 1'b0;
		#1 chk(rdata, e);
	endtask
	task automatic outp(input logic [7:0] e);
		@(posedge ref_clk);
		#1 chk(outs, e);
	endtask
	// Warm reset only; the cold flag must survive it
	task automatic rst;
		@(posedge ref_clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
	endtask
	task automatic frame(input logic s);
		@(posedge ref_clk);
		rx_frame_done <= 1'b1;
		rx_stop_bit <= s;
		@(posedge ref_clk);
		rx_frame_done <= 1'b0;
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Cold start under reset, then the register sequence
	initial begin
		repeat (5) @(posedge ref_clk);
		cold_power_on <= 1'b0;
		repeat (15) @(posedge ref_clk);
		rst_n <= 1'b1;
		rd(8'h87, 8'h10);
		rd(8'h00, 8'h00);
		wr(8'h87, 8'h00);
		rd(8'h87, 8'h00);
		wr(8'h87, 8'h10);
		rd(8'h87, 8'h10);
		rst;
		rd(8'h87, 8'h10);
		wr(8'h87, 8'h2C);
		rd(8'h87, 8'h0C);
		rst;
		rd(8'h87, 8'h00);
		wr(8'h87, 8'h02);
		outp(8'h08);
		rst;
		outp(8'h00);
		wr(8'h87, 8'h01);
		outp(8'h10);
		@(posedge ref_clk);
		irq_event <= 1'b1;
		@(posedge ref_clk);
		irq_event <= 1'b0;
		outp(8'h00);
		wr(8'hA7, 8'hFF);
		outp(8'h07);
		rd(8'hA7, 8'h07);
		wr(8'h98, 8'h40);
		wr(8'h87, 8'h40);
		outp(8'h27);
		chk({7'h00, stop_check_en}, 8'h01);
		frame(1'b0);
		rd(8'h98, 8'hC0);
		frame(1'b1);
		rd(8'h98, 8'hC0);
		wr(8'h98, 8'h40);
		rd(8'h98, 8'h40);
		wr(8'h87, 8'h00);
		wr(8'h98, 8'hC0);
		rd(8'h98, 8'hC0);
		chk({7'h00, stop_check_en}, 8'h00);
		frame(1'b0);
		wr(8'h87, 8'h40);
		rd(8'h98, 8'h40);
		wr(8'h87, 8'h80);
		outp(8'hE7);
		wr(8'h98, 8'h00);
		outp(8'h07);
		end_sim;
	end
endmodule // test_power_control_register
